// [port3_txq_split_priority_cfg.sv]
// ahb-lite register bank selecting port-3 transmit queue scheduling
//
// Register access over AHB-Lite was chosen for this implementation.
`include "txq_split_cfg.svh"
// Functional notes
// - all select bits clear, global enable clear: strict priority
// - all set, four queues: 8:4:2:1 weighting
// - all set, two queues: 2:1 weighting
// - low seven bits read-only reserved
// - bit 7 read/write select per queue
module port3_txq_split_priority_cfg
  import txq_split_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  input  wire logic        two_queue,
  input  wire logic [3:0]  transmit_queue_pending,
  input  wire logic        transmit_queue_take,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [3:0]  transmit_queue_grant,
  output logic      [1:0]  sched_mode_q
);
  logic [3:0] sel_q;
  logic       global_en_q;
  logic       wr_pend_q;
  logic [9:0] wr_addr_q;
  logic [31:0] hrdata_q;
  logic [1:0]  mode_q;

  wire addr_take = hsel & hready & (htrans == `HTRANS_NONSEQ) & ce;
  wire [9:0] a = haddr[9:0];

  function automatic logic [9:0] byte_addr(input logic [7:0] idx);
    byte_addr = {idx, 2'b00};
  endfunction

  // decode: printed offsets are not word aligned, so each is an index
  wire hit_q3 = (a == byte_addr(`IDX_Q3_SPLIT));
  wire hit_q2 = (a == byte_addr(`OFS_Q2_SPLIT));
  wire hit_q1 = (a == byte_addr(`OFS_Q1_SPLIT));
  wire hit_q0 = (a == byte_addr(`OFS_Q0_SPLIT));
  wire hit_gl = (a == byte_addr(`IDX_GLOBAL_CTRL));
  wire [3:0] hit_sel = {hit_q3, hit_q2, hit_q1, hit_q0};
  wire [3:0] wsel = {wr_addr_q == byte_addr(`IDX_Q3_SPLIT),
                     wr_addr_q == byte_addr(`OFS_Q2_SPLIT),
                     wr_addr_q == byte_addr(`OFS_Q1_SPLIT),
                     wr_addr_q == byte_addr(`OFS_Q0_SPLIT)};
  wire wr_gl = wr_addr_q == byte_addr(`IDX_GLOBAL_CTRL);

  // reserved bits always read back their default, writes are dropped
  wire [7:0] rd_split = {(|(hit_sel & sel_q)), `RSVD_RESET};
  wire [7:0] rd_gl = {4'h0, global_en_q, 3'h0};
  wire [31:0] rd_d = (|hit_sel) ? {24'h00_0000, rd_split}
                   : hit_gl ? {24'h00_0000, rd_gl} : 32'h0000_0000;

  // mode: select bits uniform decide strict or weighted; global enable overrides strict
  wire all_clr = (sel_q == 4'h0);
  wire all_set = (sel_q == 4'hf);
  wire [1:0] mode_d = (all_clr && !global_en_q) ? 2'(sched_strict)
                    : all_set ? 2'(sched_weighted)
                    : 2'(sched_mixed);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 10'h000;
    end else if (ce && hready) begin
      wr_pend_q <= addr_take & hwrite & (hsize == `HSIZE_WORD);
      wr_addr_q <= a;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sel_q       <= {4{`SEL_RESET}};
      global_en_q <= `GLOBAL_EN_RESET;
    end else if (ce && wr_pend_q) begin
      for (int i = 0; i < 4; i++) begin
        if (wsel[i]) sel_q[i] <= hwdata[`SEL_BIT];
      end
      if (wr_gl) global_en_q <= hwdata[`GLOBAL_EN_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0000_0000;
      mode_q   <= 2'(sched_strict);
    end else if (ce) begin
      if (addr_take && !hwrite) hrdata_q <= rd_d;
      mode_q <= mode_d;
    end
  end

  // zero wait states: the slave never stretches and always answers okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  assign hrdata = hrdata_q;
  assign sched_mode_q = mode_q;

  txq_weight_sched #(.QN(4)) u_sched (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .ce         (ce),
    .mode       (sched_mode_t'(mode_q)),
    .two_queue  (two_queue),
    .pending    (transmit_queue_pending),
    .grant_take (transmit_queue_take),
    .grant_q    (transmit_queue_grant)
  );
endmodule

// [port3_txq_split_priority_cfg_tb_top.sv]
// self-checking bench for the port-3 transmit-queue split bank
`include "txq_split_cfg.svh"
module port3_txq_split_priority_cfg_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk = 0, hresetn = 0, ce = 1, hsel = 0, hwrite = 0, two_queue = 0, take = 0;
  logic [31:0] haddr = 0, hwdata = 0, rd, seed = 32'h0001_2575, hrdata;
  logic [1:0]  htrans = 0, mode;
  logic [3:0]  pend = 0, grant;
  logic        hreadyout, hresp;
  int          errors = 0, checks_done = 0, cnt[4];
  always #5 hclk = ~hclk;
  port3_txq_split_priority_cfg DUT (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite,
    .hsize(`HSIZE_WORD), .hwdata, .hready(hreadyout), .two_queue,
    .transmit_queue_pending(pend), .transmit_queue_take(take), .hrdata, .hreadyout, .hresp,
    .transmit_queue_grant(grant), .sched_mode_q(mode));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic [3:0] hi(input logic [3:0] p);
    for (int i = 3; i >= 0; i--) if (p[i]) return 4'h1 << i;
    return 4'h0;
  endfunction
  // share of 30 takes: 8:4:2:1 over 15, or 2:1 over 3 with only queues 3 and 0
  function automatic int wexp(input logic two, input int i);
    return two ? (i == 3 ? 20 : (i == 0 ? 10 : 0)) : 2 << i;
  endfunction
  task finish_test;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 16);
    if (n >= 16) begin
      errors++;
      finish_test();
    end
  endtask
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1;
    haddr <= a;
    hwrite <= w;
    htrans <= `HTRANS_NONSEQ;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
    chk("hresp", 32'h0000_0000, {31'h0, hresp});
  endtask
  task tally(input logic two);
    cnt = '{0, 0, 0, 0};
    // credits left from the previous mode can take up to fifteen grants to drain
    repeat (16) @(posedge hclk);
    repeat (30) begin
      @(posedge hclk);
      for (int i = 0; i < 4; i++) cnt[i] += int'(grant[i]);
    end
    for (int i = 0; i < 4; i++) chk("share", wexp(two, i), cnt[i]);
  endtask
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1;
    for (int i = 0; i < 4; i++) begin
      xfer(0, 32'h0000_02dc + 4 * i, 0);
      chk("split reset", 32'h0000_0080, rd);
    end
    chk("mode reset", 32'h0000_0001, {30'h0, mode});
    xfer(0, 32'h0000_0100, 0);
    chk("unmapped", 32'h0000_0000, rd);
    for (int i = 1; i < 4; i++) begin
      seed = xs(seed);
      xfer(1, 32'h0000_02dc + 4 * i, seed);
      xfer(0, 32'h0000_02dc + 4 * i, 0);
      chk("split rw", {24'h00_0000, seed[7], 7'h00}, rd);
    end
    for (int i = 0; i < 4; i++) xfer(1, 32'h0000_02dc + 4 * i, 0);
    repeat (2) @(posedge hclk);
    chk("mode strict", 32'h0000_0000, {30'h0, mode});
    repeat (8) begin
      seed = xs(seed);
      pend <= seed[3:0];
      repeat (2) @(posedge hclk);
      chk("strict grant", {28'h0, hi(seed[3:0])}, {28'h0, grant});
    end
    xfer(1, 32'h0000_0014, 32'h0000_0008);
    xfer(0, 32'h0000_0014, 0);
    chk("global rw", 32'h0000_0008, rd);
    repeat (2) @(posedge hclk);
    chk("mode global", 32'h0000_0002, {30'h0, mode});
    xfer(1, 32'h0000_0014, 0);
    repeat (2) @(posedge hclk);
    chk("mode strict again", 32'h0000_0000, {30'h0, mode});
    // software keeps the select bits alike in every queue register
    for (int i = 0; i < 4; i++) xfer(1, 32'h0000_02dc + 4 * i, 32'h0000_0080);
    pend <= 4'hf;
    take <= 1;
    tally(0);
    pend <= 4'h9;
    two_queue <= 1;
    tally(1);
    finish_test();
  end
endmodule

// [txq_split_cfg.svh]
// constants for the port-3 transmit-queue split register bank
`ifndef TXQ_SPLIT_CFG_SVH
`define TXQ_SPLIT_CFG_SVH
`define OFS_Q3_SPLIT      8'h00
`define OFS_Q2_SPLIT      8'hb8
`define OFS_Q1_SPLIT      8'hb9
`define OFS_Q0_SPLIT      8'hba
`define OFS_GLOBAL_CTRL   8'h00
`define IDX_Q3_SPLIT      8'hb7
`define IDX_GLOBAL_CTRL   8'h05
`define SEL_BIT           7
`define GLOBAL_EN_BIT     3
`define SEL_RESET         1'b1
`define RSVD_RESET        7'h00
`define GLOBAL_EN_RESET   1'b0
`define HTRANS_NONSEQ     2'b10
`define HSIZE_WORD        3'b010
`define WEIGHT_4Q         16'h8421
`define WEIGHT_2Q         8'h21
`endif

// [txq_split_pkg.sv]
// types for the port-3 transmit-queue split register bank
package txq_split_pkg;
  typedef enum logic [1:0] {
    sched_strict,
    sched_weighted,
    sched_mixed
  } sched_mode_t;
endpackage

// [txq_split_properties.sv]
// concurrent checks on the port-3 transmit-queue split bank
module txq_split_properties (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        ce,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        two_queue,
  input wire logic [3:0]  transmit_queue_pending,
  input wire logic        transmit_queue_take,
  input wire logic [31:0] hrdata,
  input wire logic [3:0]  transmit_queue_grant,
  input wire logic [1:0]  sched_mode_q
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_rd;
    hsel && hready && ce && htrans == 2'h2 && !hwrite
      && haddr inside {32'h0000_02dc, 32'h0000_02e0, 32'h0000_02e4, 32'h0000_02e8};
  endsequence
  sequence s_q0_taken(logic [3:0] p, logic two);
    sched_mode_q == 2'h1 && ce && two_queue == two && transmit_queue_pending == p
      && transmit_queue_take && transmit_queue_grant == 4'h1;
  endsequence
  property p_rsvd;
    s_rd |=> hrdata[6:0] == 7'h00 && hrdata[31:8] == 24'h00_0000;
  endproperty
  property p_strict;
    sched_mode_q == 2'h0 && ce && transmit_queue_pending[3] |=> transmit_queue_grant == 4'h8;
  endproperty
  // grant may only name a queue that had a frame the cycle before
  property p_grant;
    ce |=> $onehot0(transmit_queue_grant)
      && (transmit_queue_grant & ~$past(transmit_queue_pending)) == 4'h0;
  endproperty
  property p_weight;
    s_q0_taken(4'hf, 1'b0) |=> transmit_queue_grant != 4'h1;
  endproperty
  property p_two;
    s_q0_taken(4'h9, 1'b1) |=> transmit_queue_grant == 4'h8;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits read nonzero");
  a_strict: assert property (p_strict) else $error("strict grant wrong");
  a_grant: assert property (p_grant) else $error("grant not pending");
  a_weight: assert property (p_weight) else $error("queue 0 served twice");
  a_two: assert property (p_two) else $error("two-queue order wrong");
endmodule
bind port3_txq_split_priority_cfg txq_split_properties u_props (.hclk, .hresetn, .ce, .hsel,
  .haddr, .htrans, .hwrite, .hready, .two_queue, .transmit_queue_pending,
  .transmit_queue_take, .hrdata, .transmit_queue_grant, .sched_mode_q);

// [txq_weight_sched.sv]
// weighted/strict transmit queue arbiter for port 3
`include "txq_split_cfg.svh"
module txq_weight_sched
  import txq_split_pkg::*;
#(
  parameter int QN = 4
) (
  input  wire logic          hclk,
  input  wire logic          hresetn,
  input  wire logic          ce,
  input  wire sched_mode_t   mode,
  input  wire logic          two_queue,
  input  wire logic [QN-1:0] pending,
  input  wire logic          grant_take,
  output logic      [QN-1:0] grant_q
);
  // the weight tables are laid out for four queues; refuse anything else at elaboration
  if (QN != 4) begin : g_bad_qn
    $error("txq_weight_sched supports four queues only");
  end

  logic [3:0] credit_q [QN];
  logic [3:0] credit_d [QN];
  logic [QN-1:0] grant_d;
  logic [15:0] w4;
  logic [7:0]  w2;
  assign w4 = `WEIGHT_4Q;
  assign w2 = `WEIGHT_2Q;

  function automatic logic [3:0] weight_of(input int q, input logic two);
    if (two) weight_of = (q == 3) ? w2[7:4] : (q == 0) ? w2[3:0] : 4'h0;
    else weight_of = w4[q*4 +: 4];
  endfunction

  always_comb begin
    logic found;
    logic refill;
    found = 1'b0;
    refill = 1'b1;
    grant_d = '0;
    for (int q = 0; q < QN; q++) credit_d[q] = credit_q[q];
    if (mode == sched_strict) begin
      for (int q = QN-1; q >= 0; q--) begin
        if (!found && pending[q]) begin
          grant_d[q] = 1'b1;
          found = 1'b1;
        end
      end
    end else begin
      // mixed settings fall to weighted service; they have no defined meaning
      for (int q = QN-1; q >= 0; q--) begin
        if (pending[q] && credit_q[q] != 4'h0) refill = 1'b0;
      end
      for (int q = QN-1; q >= 0; q--) begin
        if (refill) credit_d[q] = weight_of(q, two_queue);
        if (!found && pending[q] && credit_d[q] != 4'h0) begin
          grant_d[q] = 1'b1;
          found = 1'b1;
          if (grant_take) credit_d[q] = credit_d[q] - 4'h1;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      grant_q <= '0;
      for (int q = 0; q < QN; q++) credit_q[q] <= 4'h0;
    end else if (ce) begin
      grant_q <= grant_d;
      for (int q = 0; q < QN; q++) credit_q[q] <= credit_d[q];
    end
  end
endmodule
